// ---- core/rqbr_regs.sv ----
// reference qualify timing, status freeze and reference 0 rate register bank
// Overview of operation
// - each reference is disqualified once its selected delay (minimum, 10 ms, 50 ms, 2.5 s) has run with a monitor flag up.
// - after both monitor flags drop, a reference is requalified after 2, 4, 6 or 8 times its disqualify delay.
// - after reset the disqualify select reads 0xAA (50 ms) and the requalify select reads 0x55 (four times).
// - writing 0x01 to the freeze register stops hardware updating the latched status so it reads stable.
// - writing 0x00 to the freeze register resumes latched status updates, and the register resets to 0x00.
// - the reference 0 base rate is a 16-bit hertz value resetting to 0x9C40 and should be a supported rate.
// - multi-byte registers are big-endian, the high byte at the lower address, assembled before use.
// - the reference 0 rate multiplier is a 16-bit factor whose product with the base rate is the reference rate.
`timescale 1ns/1ps
module rqbr_regs
#(
    parameter int unsigned TICK_CYC = rqbr_pkg::TICK_CYC_DFLT
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // host register port
    input wire rqbr_pkg::rqbr_req_t host_req_in,
    output logic [7:0] host_rdata_out,
    output logic host_rvalid_out,
    // monitor indicators from the reference pins
    input wire rqbr_pkg::rqbr_mon_t [rqbr_pkg::NUM_REF-1:0] mon_in,
    // results
    output logic [rqbr_pkg::NUM_REF-1:0] ref_qualified_out,
    output logic status_frozen_out,
    output logic [15:0] ref0_base_rate_out,
    output logic [15:0] ref0_rate_multiplier_out,
    output logic base_rate_unsupported_out
);
    logic [7:0] disq_q, disq_d;
    logic [7:0] req_q, req_d;
    logic [7:0] frz_q, frz_d;
    logic [15:0] base_q, base_d;
    logic [15:0] mult_q, mult_d;
    logic [7:0] base_hi_q, base_hi_d;
    logic [7:0] mult_hi_q, mult_hi_d;
    logic [3:0] lstat_q, lstat_d;
    logic [3:0] accum_q, accum_d;
    logic [7:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] div_q, div_d;
    logic tick_q, tick_d;
    logic [rqbr_pkg::NUM_REF-1:0] fail_s1_q, fail_s2_q;
    logic [rqbr_pkg::NUM_REF-1:0] fail_raw;
    logic [rqbr_pkg::NUM_REF-1:0] disq_evt;
    logic frozen;
    logic clr_wr;
    logic wrote_disq_q, wrote_req_q;

    assign frozen = (frz_q == rqbr_pkg::FRZ_LOCK);
    assign clr_wr = host_req_in.wr && host_req_in.addr == rqbr_pkg::ADDR_LSTAT;

    // 1 ms enable divider
    always_comb
    begin
        tick_d = 1'b0;
        div_d = div_q + 32'h1;
        if (div_q >= TICK_CYC - 1)
        begin
            div_d = '0;
            tick_d = 1'b1;
        end
    end

    // per-reference combined monitor flag and soak timer, fed from the two-stage synchronised flag
    generate
        for (genvar i = 0; i < rqbr_pkg::NUM_REF; i++)
        begin : g_ref
            assign fail_raw[i] = mon_in[i].coarse_rate_check | mon_in[i].single_period_check;
            rqbr_soak u_soak
            (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .tick_in(tick_q),
                .fail_in(fail_s2_q[i]),
                .disq_code_in(disq_q[2*i +: rqbr_pkg::CODE_W]),
                .req_code_in(req_q[2*i +: rqbr_pkg::CODE_W]),
                .qualified_out(ref_qualified_out[i]),
                .disq_evt_out(disq_evt[i])
            );
        end
    endgenerate

    // register writes, big-endian staging and latched status
    always_comb
    begin
        disq_d = disq_q;
        req_d = req_q;
        frz_d = frz_q;
        base_d = base_q;
        mult_d = mult_q;
        base_hi_d = base_hi_q;
        mult_hi_d = mult_hi_q;
        if (host_req_in.wr)
        begin
            case (host_req_in.addr)
                rqbr_pkg::ADDR_DISQ: disq_d = host_req_in.wdata;
                rqbr_pkg::ADDR_REQ: req_d = host_req_in.wdata;
                rqbr_pkg::ADDR_FRZ: frz_d = host_req_in.wdata;
                rqbr_pkg::ADDR_BASE_HI: base_hi_d = host_req_in.wdata;
                rqbr_pkg::ADDR_BASE_LO: base_d = {base_hi_q, host_req_in.wdata};
                rqbr_pkg::ADDR_MULT_HI: mult_hi_d = host_req_in.wdata;
                rqbr_pkg::ADDR_MULT_LO: mult_d = {mult_hi_q, host_req_in.wdata};
                default: ;
            endcase
        end
        // events always gather; a clear write drops bits but a same-cycle event wins
        accum_d = (clr_wr ? (accum_q & ~host_req_in.wdata[3:0]) : accum_q) | disq_evt;
        lstat_d = clr_wr ? (lstat_q & ~host_req_in.wdata[3:0]) : lstat_q;
        if (!frozen)
            lstat_d = lstat_d | accum_d;
    end

    // register reads, answered the cycle after the strobe
    always_comb
    begin
        rvalid_d = host_req_in.rd;
        rdata_d = 8'h00;
        if (host_req_in.rd)
        begin
            case (host_req_in.addr)
                rqbr_pkg::ADDR_DISQ: rdata_d = disq_q;
                rqbr_pkg::ADDR_REQ: rdata_d = req_q;
                rqbr_pkg::ADDR_FRZ: rdata_d = frz_q;
                rqbr_pkg::ADDR_BASE_HI: rdata_d = base_q[15:8];
                rqbr_pkg::ADDR_BASE_LO: rdata_d = base_q[7:0];
                rqbr_pkg::ADDR_MULT_HI: rdata_d = mult_q[15:8];
                rqbr_pkg::ADDR_MULT_LO: rdata_d = mult_q[7:0];
                rqbr_pkg::ADDR_LSTAT: rdata_d = {4'h0, lstat_q};
                rqbr_pkg::ADDR_QSTAT: rdata_d = {4'h0, ref_qualified_out};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // all state registers of the bank
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            disq_q <= rqbr_pkg::RST_DISQ;
            req_q <= rqbr_pkg::RST_REQ;
            frz_q <= rqbr_pkg::RST_FRZ;
            base_q <= rqbr_pkg::RST_BASE;
            mult_q <= rqbr_pkg::RST_MULT;
            base_hi_q <= rqbr_pkg::RST_BASE[15:8];
            mult_hi_q <= rqbr_pkg::RST_MULT[15:8];
            lstat_q <= 4'h0;
            accum_q <= 4'h0;
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
            div_q <= '0;
            tick_q <= 1'b0;
            fail_s1_q <= '0;
            fail_s2_q <= '0;
            wrote_disq_q <= 1'b0;
            wrote_req_q <= 1'b0;
        end
        else
        begin
            disq_q <= disq_d;
            req_q <= req_d;
            frz_q <= frz_d;
            base_q <= base_d;
            mult_q <= mult_d;
            base_hi_q <= base_hi_d;
            mult_hi_q <= mult_hi_d;
            lstat_q <= lstat_d;
            accum_q <= accum_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            div_q <= div_d;
            tick_q <= tick_d;
            fail_s1_q <= fail_raw;
            fail_s2_q <= fail_s1_q;
            wrote_disq_q <= wrote_disq_q | (host_req_in.wr && host_req_in.addr == rqbr_pkg::ADDR_DISQ);
            wrote_req_q <= wrote_req_q | (host_req_in.wr && host_req_in.addr == rqbr_pkg::ADDR_REQ);
        end
    end

    // outputs
    assign host_rdata_out = rdata_q;
    assign host_rvalid_out = rvalid_q;
    assign status_frozen_out = frozen;
    assign ref0_base_rate_out = base_q;
    assign ref0_rate_multiplier_out = mult_q;
    assign base_rate_unsupported_out = !rqbr_pkg::rate_supported(base_q);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_wr(logic [7:0] a);
        host_req_in.wr && host_req_in.addr == a;
    endsequence

    AST_RESET_SELECTS: assert property (!wrote_disq_q && !wrote_req_q
        |-> disq_q == 8'hAA && req_q == 8'h55)
        else $error("delay selects lost their reset values");
    AST_FREEZE_HOLDS: assert property (frozen && !clr_wr |=> $stable(lstat_q))
        else $error("latched status changed while frozen");
    AST_FREEZE_ON_WRITE: assert property (s_wr(8'h0D) ##0 host_req_in.wdata == 8'h01
        |=> status_frozen_out [*1] ##1 1'b1)
        else $error("lock write did not freeze status");
    AST_UNFREEZE_MERGE: assert property (s_wr(8'h0D) ##0 host_req_in.wdata == 8'h00
        ##1 !host_req_in.wr
        |=> lstat_q == ($past(lstat_q) | $past(accum_q) | $past(disq_evt)))
        else $error("status not updated after unlock");
    AST_BASE_COMMIT: assert property (s_wr(8'h11)
        |=> base_q == {$past(base_hi_q), $past(host_req_in.wdata)})
        else $error("base rate not assembled big-endian");
    AST_BASE_HI_STAGES: assert property (s_wr(8'h10) |=> $stable(base_q))
        else $error("base rate changed on high byte alone");
    AST_MULT_COMMIT: assert property (s_wr(8'h12) ##1 s_wr(8'h13)
        |=> mult_q == {$past(host_req_in.wdata, 2), $past(host_req_in.wdata)})
        else $error("multiplier not assembled from its two bytes");
    AST_RATE_FLAG: assert property (s_wr(8'h11) ##0 host_req_in.wdata == 8'h40 ##0 base_hi_q == 8'h9C
        |=> !base_rate_unsupported_out)
        else $error("40 kHz base rate flagged unsupported");
endmodule

// ---- core/rqbr_pkg.sv ----
// constants, types and helpers shared by the reference qualify and base rate register bank
package rqbr_pkg;
    // host register port byte offsets
    localparam logic [7:0] ADDR_DISQ = 8'h0B;
    localparam logic [7:0] ADDR_REQ = 8'h0C;
    localparam logic [7:0] ADDR_FRZ = 8'h0D;
    localparam logic [7:0] ADDR_BASE_HI = 8'h10;
    localparam logic [7:0] ADDR_BASE_LO = 8'h11;
    localparam logic [7:0] ADDR_MULT_HI = 8'h12;
    localparam logic [7:0] ADDR_MULT_LO = 8'h13;
    localparam logic [7:0] ADDR_LSTAT = 8'h20;
    localparam logic [7:0] ADDR_QSTAT = 8'h21;

    // values after reset, and the freeze register lock and open codes
    localparam logic [7:0] RST_DISQ = 8'hAA;
    localparam logic [7:0] RST_REQ = 8'h55;
    localparam logic [7:0] RST_FRZ = 8'h00;
    localparam logic [15:0] RST_BASE = 16'h9C40;
    localparam logic [15:0] RST_MULT = 16'h0F30;
    localparam logic [7:0] FRZ_LOCK = 8'h01;
    localparam logic [7:0] FRZ_OPEN = 8'h00;

    // field layout: two bits per reference
    localparam int NUM_REF = 4;
    localparam int CODE_W = 2;

    // timing: soak delays counted in 1 ms ticks of a 20 MHz clock
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC_DFLT = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DLY_MIN_MS = 0;
    localparam int unsigned DLY_10_MS = 10;
    localparam int unsigned DLY_50_MS = 50;
    localparam int unsigned DLY_2P5_S = 2500;
    localparam int CNT_W = 15;

    // one host register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rqbr_req_t;

    // monitor indicators of one reference
    typedef struct packed {
        logic coarse_rate_check;
        logic single_period_check;
    } rqbr_mon_t;

    // base rates that the rate engine supports
    function automatic logic rate_supported(input logic [15:0] r);
        case (r)
            16'h03E8, 16'h07D0, 16'h1388, 16'h186A, 16'h1F40,
            16'h2710, 16'h30D4, 16'h61A8, 16'h9C40: rate_supported = 1'b1;
            default: rate_supported = 1'b0;
        endcase
    endfunction
endpackage

// ---- core/rqbr_soak.sv ----
// guard soak timer of one reference: disqualify and requalify delays
`timescale 1ns/1ps
module rqbr_soak
(
    // clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // 1 ms enable and synchronised monitor failure
    input wire logic tick_in,
    input wire logic fail_in,
    // delay selection codes
    input wire logic [1:0] disq_code_in,
    input wire logic [1:0] req_code_in,
    // result
    output logic qualified_out,
    output logic disq_evt_out
);
    typedef enum logic [1:0] {S_OK, S_FAIL_SOAK, S_BAD, S_REQ_SOAK} rqbr_soak_st_t;

    rqbr_soak_st_t st_q, st_d;
    logic [rqbr_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [rqbr_pkg::CNT_W-1:0] dis_tgt;
    logic [rqbr_pkg::CNT_W-1:0] req_tgt;
    logic [3:0] req_fac;
    logic evt_q, evt_d;

    // delay targets in ticks from the selection codes
    always_comb
    begin
        case (disq_code_in)
            2'h0: dis_tgt = rqbr_pkg::CNT_W'(rqbr_pkg::DLY_MIN_MS / rqbr_pkg::TICK_MS);
            2'h1: dis_tgt = rqbr_pkg::CNT_W'(rqbr_pkg::DLY_10_MS / rqbr_pkg::TICK_MS);
            2'h2: dis_tgt = rqbr_pkg::CNT_W'(rqbr_pkg::DLY_50_MS / rqbr_pkg::TICK_MS);
            default: dis_tgt = rqbr_pkg::CNT_W'(rqbr_pkg::DLY_2P5_S / rqbr_pkg::TICK_MS);
        endcase
        req_fac = {1'b0, req_code_in, 1'b0} + 4'h2;
        req_tgt = rqbr_pkg::CNT_W'(32'(dis_tgt) * 32'(req_fac));
    end

    // soak state machine, counter restarts when a disqualify or requalify soak begins
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        evt_d = 1'b0;
        case (st_q)
            S_OK:
            begin
                if (fail_in)
                begin
                    st_d = S_FAIL_SOAK;
                    cnt_d = '0;
                end
            end
            S_FAIL_SOAK:
            begin
                if (!fail_in)
                    st_d = S_OK;
                else if (cnt_q >= dis_tgt)
                begin
                    st_d = S_BAD;
                    evt_d = 1'b1;
                end
                else if (tick_in)
                    cnt_d = cnt_q + 1'b1;
            end
            S_BAD:
            begin
                if (!fail_in)
                begin
                    st_d = S_REQ_SOAK;
                    cnt_d = '0;
                end
            end
            S_REQ_SOAK:
            begin
                if (fail_in)
                    st_d = S_BAD;
                else if (cnt_q >= req_tgt)
                    st_d = S_OK;
                else if (tick_in)
                    cnt_d = cnt_q + 1'b1;
            end
            default: st_d = S_OK;
        endcase
    end

    // state registers
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_q <= S_OK;
            cnt_q <= '0;
            evt_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            evt_q <= evt_d;
        end
    end

    assign qualified_out = (st_q == S_OK) || (st_q == S_FAIL_SOAK);
    assign disq_evt_out = evt_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    AST_FAIL_STARTS_SOAK: assert property (st_q == S_OK && fail_in |=> st_q == S_FAIL_SOAK && cnt_q == '0)
        else $error("soak did not restart on failure");
    AST_DISQ_AT_TARGET: assert property (st_q == S_FAIL_SOAK && fail_in && cnt_q >= dis_tgt
        |=> !qualified_out && disq_evt_out)
        else $error("reference not disqualified at delay");
    AST_NO_EARLY_DISQ: assert property ($fell(qualified_out)
        |-> $past(cnt_q) >= $past(dis_tgt) && $past(fail_in))
        else $error("reference disqualified early");
    AST_REQ_AT_TARGET: assert property (st_q == S_REQ_SOAK && !fail_in && cnt_q >= req_tgt
        |=> qualified_out)
        else $error("reference not requalified at delay");
    AST_NO_EARLY_REQ: assert property ($rose(qualified_out)
        |-> $past(st_q) == S_REQ_SOAK && $past(cnt_q) >= $past(req_tgt))
        else $error("reference requalified early");
    AST_REQ_ABORT: assert property (st_q == S_REQ_SOAK && fail_in |=> st_q == S_BAD ##1 !qualified_out)
        else $error("requalify soak not aborted by failure");
endmodule

// ---- test/test_rqbr_regs.sv ----
// self-checking bench for the reference qualify and base rate register bank
`timescale 1ns/1ps
module test_rqbr_regs;
    localparam int unsigned T = 4;
    // stimulus and observed signals
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    rqbr_pkg::rqbr_req_t host_req = '0;
    rqbr_pkg::rqbr_mon_t [rqbr_pkg::NUM_REF-1:0] mon = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic [rqbr_pkg::NUM_REF-1:0] qual;
    logic frozen;
    logic [15:0] base;
    logic [15:0] mult;
    logic unsup;
    logic [7:0] exp_q[$];
    int num_errors = 0;
    int comparisons = 0;
    logic [15:0] rates[9] = '{16'h03E8, 16'h07D0, 16'h1388, 16'h186A, 16'h1F40,
                             16'h2710, 16'h30D4, 16'h61A8, 16'h9C40};
    int dly_ms[4] = '{rqbr_pkg::DLY_MIN_MS, rqbr_pkg::DLY_10_MS, rqbr_pkg::DLY_50_MS,
                      rqbr_pkg::DLY_2P5_S};
    int fac[4] = '{2, 4, 6, 8};
    int reqc[4] = '{3, 2, 1, 0};

    // device under test with short millisecond tick
    rqbr_regs #(.TICK_CYC(T)) dut_u (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .host_req_in(host_req),
        .host_rdata_out(rdata),
        .host_rvalid_out(rvalid),
        .mon_in(mon),
        .ref_qualified_out(qual),
        .status_frozen_out(frozen),
        .ref0_base_rate_out(base),
        .ref0_rate_multiplier_out(mult),
        .base_rate_unsupported_out(unsup)
    );

    // 20 MHz clock
    initial
    begin
        forever #25 clk_in = ~clk_in;
    end

    task automatic test_done();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one host access: strobe for one cycle, taken at the next edge
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        host_req <= {w, r, a, d};
        @(posedge clk_in);
        host_req <= '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic settle();
        @(posedge clk_in);
        #1;
    endtask

    // wait for a qualify level, delay given in ticks, and check the cycle window
    task automatic wait_q(input int i, input logic v, input int ticks);
        int n;
        int lo;
        int hi;
        n = 0;
        lo = (ticks * T > T) ? ticks * T - T + 2 : 2;
        hi = ticks * T + 8;
        while (qual[i] !== v && n <= hi)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        comparisons++;
        if (n < lo || n > hi)
        begin
            num_errors++;
            $display("[ERR] %0t ref %0d took %0d cycles, window %0d..%0d", $time, i, n, lo, hi);
            if (n > hi)
                test_done();
        end
    endtask

    // read data watcher: compares each answer with the oldest note
    always @(posedge clk_in)
    begin
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk({8'h00, rdata}, 16'hFFFF, "unexpected read answer");
            else
                chk({8'h00, rdata}, {8'h00, exp_q.pop_front()}, "read data");
        end
    end

    // main sequence
    initial
    begin
        logic [15:0] v;
        logic [15:0] prev;
        void'($urandom(32'hBB7D));
        repeat (4) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(rqbr_pkg::ADDR_DISQ, 8'hAA);
        rd(rqbr_pkg::ADDR_REQ, 8'h55);
        rd(rqbr_pkg::ADDR_FRZ, 8'h00);
        rd(rqbr_pkg::ADDR_BASE_HI, 8'h9C);
        rd(rqbr_pkg::ADDR_BASE_LO, 8'h40);
        rd(rqbr_pkg::ADDR_MULT_HI, 8'h0F);
        rd(rqbr_pkg::ADDR_MULT_LO, 8'h30);
        rd(8'h40, 8'h00);
        wr(rqbr_pkg::ADDR_QSTAT, 8'h00);
        rd(rqbr_pkg::ADDR_QSTAT, 8'h0F);
        chk({15'h0000, unsup}, 16'h0000, "reset rate flagged");
        // short flag on ref 2 must not disqualify it
        @(posedge clk_in);
        mon[2] <= 2'b01;
        repeat (20) @(posedge clk_in);
        mon[2] <= 2'b00;
        repeat (300) @(posedge clk_in);
        #1;
        chk({12'h000, qual}, 16'h000F, "short flag disqualified");
        rd(rqbr_pkg::ADDR_LSTAT, 8'h00);
        // every supported base rate, committed on the low byte
        prev = 16'h9C40;
        for (int k = 0; k < 9; k++)
        begin
            wr(rqbr_pkg::ADDR_BASE_HI, rates[k][15:8]);
            settle();
            chk(base, prev, "base moved on high byte");
            wr(rqbr_pkg::ADDR_BASE_LO, rates[k][7:0]);
            settle();
            chk(base, rates[k], "base rate");
            chk({15'h0000, unsup}, 16'h0000, "supported rate flagged");
            rd(rqbr_pkg::ADDR_BASE_HI, rates[k][15:8]);
            prev = rates[k];
        end
        v = 16'($urandom) | 16'h0001;
        wr(rqbr_pkg::ADDR_BASE_HI, v[15:8]);
        wr(rqbr_pkg::ADDR_BASE_LO, v[7:0]);
        settle();
        chk({15'h0000, unsup}, 16'h0001, "odd rate not flagged");
        v = 16'($urandom);
        wr(rqbr_pkg::ADDR_MULT_HI, v[15:8]);
        wr(rqbr_pkg::ADDR_MULT_LO, v[7:0]);
        settle();
        chk(mult, v, "multiplier");
        rd(rqbr_pkg::ADDR_MULT_HI, v[15:8]);
        rd(rqbr_pkg::ADDR_MULT_LO, v[7:0]);
        // halved reference input: rates programmed for half of a 155.52 MHz clock
        wr(rqbr_pkg::ADDR_BASE_HI, 8'h9C);
        wr(rqbr_pkg::ADDR_BASE_LO, 8'h40);
        // multiplier bytes back to back, high byte first
        @(posedge clk_in);
        host_req <= {1'b1, 1'b0, rqbr_pkg::ADDR_MULT_HI, 8'h07};
        @(posedge clk_in);
        host_req <= {1'b1, 1'b0, rqbr_pkg::ADDR_MULT_LO, 8'h98};
        @(posedge clk_in);
        host_req <= '0;
        settle();
        chk(mult, 16'h0798, "back to back multiplier");
        comparisons++;
        if (32'(base) * 32'(mult) !== 32'd77760000)
        begin
            num_errors++;
            $display("[ERR] %0t halved rate product wrong", $time);
        end
        // all delay codes: ref i uses disqualify code i, requalify code 3-i
        wr(rqbr_pkg::ADDR_DISQ, 8'hE4);
        wr(rqbr_pkg::ADDR_REQ, 8'h1B);
        rd(rqbr_pkg::ADDR_REQ, 8'h1B);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_in);
            mon[i] <= ($urandom & 1) ? 2'b10 : 2'b01;
            wait_q(i, 1'b0, dly_ms[i]);
            chk({12'h000, qual}, 16'h000F ^ (16'h0001 << i), "other refs");
            rd(rqbr_pkg::ADDR_LSTAT, 8'h01 << i);
            wr(rqbr_pkg::ADDR_LSTAT, 8'h01 << i);
            @(posedge clk_in);
            mon[i] <= 2'b00;
            wait_q(i, 1'b1, fac[reqc[i]] * dly_ms[i]);
        end
        // freeze holds latched status, unfreeze releases the event
        wr(rqbr_pkg::ADDR_FRZ, 8'h02);
        settle();
        chk({15'h0000, frozen}, 16'h0000, "freeze by other value");
        wr(rqbr_pkg::ADDR_FRZ, rqbr_pkg::FRZ_LOCK);
        settle();
        chk({15'h0000, frozen}, 16'h0001, "freeze flag");
        rd(rqbr_pkg::ADDR_FRZ, 8'h01);
        @(posedge clk_in);
        mon[0] <= 2'b01;
        wait_q(0, 1'b0, 0);
        rd(rqbr_pkg::ADDR_LSTAT, 8'h00);
        wr(rqbr_pkg::ADDR_FRZ, rqbr_pkg::FRZ_OPEN);
        rd(rqbr_pkg::ADDR_LSTAT, 8'h01);
        chk({15'h0000, frozen}, 16'h0000, "unfreeze flag");
        @(posedge clk_in);
        mon[0] <= 2'b00;
        wait_q(0, 1'b1, 0);
        repeat (4) @(posedge clk_in);
        chk(16'(exp_q.size()), 16'h0000, "reads left unanswered");
        test_done();
    end
endmodule
